// file: logic/sdc_core.sv
// Command decode, bank tracking, mode word and burst engine of a
// two-bank synchronous DRAM. Pins arrive from the memory controller;
// the array itself sits outside and answers reads in the same cycle.
//
// How it works
// - Strobes decode to nop, stop, read, write, open, close, refresh, load.
// - Open takes row from lines 0-10; bank always from line 11.
// - Column is lines 0-7; lines 8 and 9 are ignored.
// - Line 10 high on a multi-word read or write selects the autoclose state.
// - Banks track six states; close hits one bank or both.
// - Mode load stores address lines 0-11 as the mode word.
// - Word fields: options 11-9, latency 6-4, type 3, length 2-0.
// - First read word appears the programmed latency after the read.
// - Burst starts at the given column; later columns are internal.
// - Burst length 1, 2, 4, 8 or full page.
// - Below full page, burst order is sequential or interleaved by the type bit.
// - Write mode zero bursts writes, first word with the command.
// - Write mode one stores one word per write; reads still burst.
// - Length, type and latency codes as listed; others reserved.
// - Refresh takes its row from an internal counter.
`timescale 1ns/1ns
`default_nettype none

module sdc_core #(
    parameter int WBUF_DEPTH = sdc_pkg::WBUF_DEPTH
) (
    input  wire logic                clk_sys,     // 100 MHz clock
    input  wire logic                arst_n,      // Async reset
    input  wire logic                clk_en,      // Freeze when low
    input  wire sdc_pkg::sdc_pins_t  pins,        // Command pins, dq in
    output logic [sdc_pkg::DQ_W-1:0] dq_out,      // Read data to pins
    output logic                     dq_oe,       // Drive dq pins
    output sdc_pkg::sdc_arr_t        arr_req,     // Read/refresh to array
    input  wire logic [sdc_pkg::DQ_W-1:0] arr_rd_data, // Array answer
    output logic                     wbuf_ready,  // Write buffer room
    output logic                     wr_valid,    // Write beat waiting
    input  wire logic                wr_ready,    // Array takes beat
    output sdc_pkg::sdc_wbeat_t      wr_beat,     // Write beat
    output sdc_pkg::sdc_bank_t [1:0] bank_state,  // Per-bank state
    output logic [sdc_pkg::ADDR_W-1:0] operating_mode_word // Mode
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    sdc_pkg::sdc_pins_t pin_s1;
    sdc_pkg::sdc_pins_t pin_s2;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1 <= sdc_pkg::PINS_RST;
            pin_s2 <= sdc_pkg::PINS_RST;
        end else if (clk_en) begin
            pin_s1 <= pins;
            pin_s2 <= pin_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic sdc_pkg::sdc_cmd_t decode_cmd(
        input sdc_pkg::sdc_pins_t p
    );
        sdc_pkg::sdc_cmd_t c;
        unique case ({p.ras_n, p.cas_n, p.we_n})
            3'b111: c = sdc_pkg::nop_cmd;
            3'b110: c = sdc_pkg::burst_stop_cmd;
            3'b101: c = sdc_pkg::read_cmd;
            3'b100: c = sdc_pkg::write_cmd;
            3'b011: c = sdc_pkg::row_open_cmd;
            3'b010: c = sdc_pkg::close_cmd;
            3'b001: c = sdc_pkg::refresh_cmd;
            3'b000: c = sdc_pkg::mode_load_cmd;
        endcase
        return p.cs_n ? sdc_pkg::deselect_cmd : c;
    endfunction

    // Reserved length codes fall back to one word
    function automatic logic [sdc_pkg::CNT_W-1:0] len_of(
        input logic [2:0] code
    );
        logic [sdc_pkg::CNT_W-1:0] n;
        unique case (code)
            sdc_pkg::BL_2:    n = 9'h002;
            sdc_pkg::BL_4:    n = 9'h004;
            sdc_pkg::BL_8:    n = 9'h008;
            sdc_pkg::BL_PAGE: n = sdc_pkg::PAGE_LEN;
            default:          n = 9'h001;
        endcase
        return n;
    endfunction

    // Column of beat k: wraps inside the burst-aligned block
    function automatic logic [sdc_pkg::COL_W-1:0] beat_col(
        input logic [sdc_pkg::COL_W-1:0] start,
        input logic [sdc_pkg::CNT_W-1:0] k,
        input logic [sdc_pkg::CNT_W-1:0] len,
        input logic                      ilv
    );
        logic [sdc_pkg::CNT_W-1:0] m9;
        logic [sdc_pkg::COL_W-1:0] mask;
        logic [sdc_pkg::COL_W-1:0] off;
        m9   = len - 9'h001;
        mask = m9[sdc_pkg::COL_W-1:0];
        off  = ilv ? ((start & mask) ^ k[sdc_pkg::COL_W-1:0])
                   : ((start & mask) + k[sdc_pkg::COL_W-1:0]);
        return (start & ~mask) | (off & mask);
    endfunction

    function automatic logic is_autoclose(input sdc_pkg::sdc_bank_t s);
        return s == sdc_pkg::read_autoclose_cmd ||
               s == sdc_pkg::write_autoclose_cmd;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Decode

    wire sdc_pkg::sdc_cmd_t cmd = decode_cmd(pin_s2);

    wire is_rd   = cmd == sdc_pkg::read_cmd;
    wire is_wr   = cmd == sdc_pkg::write_cmd;
    wire is_open = cmd == sdc_pkg::row_open_cmd;
    wire is_cls  = cmd == sdc_pkg::close_cmd;
    wire is_stop = cmd == sdc_pkg::burst_stop_cmd;
    wire is_ref  = cmd == sdc_pkg::refresh_cmd;
    wire is_load = cmd == sdc_pkg::mode_load_cmd;

    wire bank_select_line  = pin_s2.addr[sdc_pkg::BANK_LINE];
    wire precharge_flag_line = pin_s2.addr[sdc_pkg::PRE_LINE];
    wire [sdc_pkg::ROW_W-1:0] cmd_row =
        pin_s2.addr[sdc_pkg::ROW_W-1:0];
    wire [sdc_pkg::COL_W-1:0] cmd_col =
        pin_s2.addr[sdc_pkg::COL_W-1:0];

    ////////////////////////////////////////////////////////////////////
    // Mode word fields

    wire [2:0] wmode = operating_mode_word[sdc_pkg::WM_HI:sdc_pkg::WM_LO];
    wire [2:0] lat   =
        operating_mode_word[sdc_pkg::LAT_HI:sdc_pkg::LAT_LO];
    wire [2:0] bl    = operating_mode_word[sdc_pkg::BL_HI:sdc_pkg::BL_LO];
    wire       btype = operating_mode_word[sdc_pkg::BT_BIT];
    wire       page  = bl == sdc_pkg::BL_PAGE;
    wire       ilv   = btype & ~page;
    wire       lat3  = lat != sdc_pkg::LAT_2;
    wire [sdc_pkg::CNT_W-1:0] bl_len = len_of(bl);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            operating_mode_word <= sdc_pkg::MODE_RST;
        end else if (clk_en && is_load) begin
            operating_mode_word <= pin_s2.addr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Burst engine

    logic                      bst_on;
    logic                      bst_wr;
    logic                      bst_bank;
    logic                      bst_page;
    logic [sdc_pkg::ROW_W-1:0] bst_row;
    logic [sdc_pkg::COL_W-1:0] bst_start;
    logic [sdc_pkg::CNT_W-1:0] bst_k;
    logic [sdc_pkg::CNT_W-1:0] bst_len;
    logic [sdc_pkg::ROW_W-1:0] open_row [sdc_pkg::BANKS];

    // Reads or writes to a closed bank are illegal and dropped
    wire start_rw = (is_rd | is_wr) &&
                    bank_state[bank_select_line] != sdc_pkg::bank_idle;

    wire [sdc_pkg::CNT_W-1:0] eff_len =
        (is_wr && wmode == sdc_pkg::WM_SINGLE) ? 9'h001 : bl_len;

    wire pre_hit = is_cls &&
                   (precharge_flag_line || bank_select_line == bst_bank);
    wire cont_beat = bst_on && !start_rw && !is_stop && !pre_hit;
    wire last_beat = bst_k == bst_len - 9'h001;
    wire done = cont_beat && !bst_page && last_beat;

    // Beat 0 comes straight from the command, later beats internally
    wire beat_v = start_rw | cont_beat;
    wire beat_wr = start_rw ? is_wr : bst_wr;
    wire beat_bank = start_rw ? bank_select_line : bst_bank;
    wire [sdc_pkg::ROW_W-1:0] beat_row =
        start_rw ? open_row[bank_select_line] : bst_row;
    wire [sdc_pkg::COL_W-1:0] beat_c =
        start_rw ? cmd_col
                 : beat_col(bst_start, bst_k, bst_len, ilv);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bst_on    <= 1'b0;
            bst_wr    <= 1'b0;
            bst_bank  <= 1'b0;
            bst_page  <= 1'b0;
            bst_row   <= '0;
            bst_start <= '0;
            bst_k     <= '0;
            bst_len   <= '0;
        end else if (clk_en) begin
            if (start_rw) begin
                bst_on    <= eff_len != 9'h001;
                bst_wr    <= is_wr;
                bst_bank  <= bank_select_line;
                bst_page  <= page && eff_len != 9'h001;
                bst_row   <= open_row[bank_select_line];
                bst_start <= cmd_col;
                bst_k     <= 9'h001;
                bst_len   <= eff_len;
            end else if (cont_beat) begin
                bst_k  <= bst_k + 9'h001;
                bst_on <= !done;
            end else begin
                bst_on <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bank states

    sdc_pkg::sdc_bank_t [1:0] next_bank_state;

    always_comb begin
        for (int b = 0; b < sdc_pkg::BANKS; b++) begin
            next_bank_state[b] = bank_state[b];
            if (is_open && bank_select_line == 1'(b) &&
                bank_state[b] == sdc_pkg::bank_idle) begin
                next_bank_state[b] = sdc_pkg::bank_active;
            end else if (is_cls && (precharge_flag_line ||
                         bank_select_line == 1'(b))) begin
                next_bank_state[b] = sdc_pkg::bank_idle;
            end else if (start_rw && bank_select_line == 1'(b)) begin
                if (eff_len == 9'h001) begin
                    next_bank_state[b] = precharge_flag_line ?
                        sdc_pkg::bank_idle : sdc_pkg::bank_active;
                end else if (is_rd) begin
                    next_bank_state[b] = precharge_flag_line ?
                        sdc_pkg::read_autoclose_cmd : sdc_pkg::bank_read;
                end else begin
                    next_bank_state[b] = precharge_flag_line ?
                        sdc_pkg::write_autoclose_cmd : sdc_pkg::bank_write;
                end
            end else if (bst_on && bst_bank == 1'(b) &&
                         (start_rw || is_stop)) begin
                next_bank_state[b] = sdc_pkg::bank_active;
            end else if (done && bst_bank == 1'(b)) begin
                next_bank_state[b] = is_autoclose(bank_state[b]) ?
                    sdc_pkg::bank_idle : sdc_pkg::bank_active;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bank_state <= '{sdc_pkg::bank_idle, sdc_pkg::bank_idle};
        end else if (clk_en) begin
            bank_state <= next_bank_state;
        end
    end

    // Row kept per bank; beats find it by the bank line, with no row address
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            open_row[0] <= '0;
            open_row[1] <= '0;
        end else if (clk_en && is_open &&
                     bank_state[bank_select_line] == sdc_pkg::bank_idle) begin
            open_row[bank_select_line] <= cmd_row;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Array requests and refresh row

    logic [sdc_pkg::ROW_W-1:0] ref_row;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ref_row <= sdc_pkg::REF_ROW_RST;
            arr_req <= '0;
        end else if (clk_en) begin
            if (is_ref) ref_row <= ref_row + 11'h001;
            arr_req.rd      <= beat_v & ~beat_wr;
            arr_req.refresh <= is_ref;
            arr_req.bank    <= beat_bank;
            arr_req.row     <= is_ref ? ref_row : beat_row;
            arr_req.col     <= beat_c;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data latency: 2 or 3 cycles after the decoded command

    logic [sdc_pkg::DQ_W-1:0] rd_hold;
    logic                     rd_hold_v;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_hold   <= '0;
            rd_hold_v <= 1'b0;
            dq_out    <= '0;
            dq_oe     <= 1'b0;
        end else if (clk_en) begin
            rd_hold   <= arr_rd_data;
            rd_hold_v <= arr_req.rd;
            dq_out    <= lat3 ? rd_hold : arr_rd_data;
            dq_oe     <= lat3 ? rd_hold_v : arr_req.rd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write buffer

    sdc_pkg::sdc_wbeat_t wb_in;
    logic                wb_in_ready;

    assign wb_in.bank = beat_bank;
    assign wb_in.row  = beat_row;
    assign wb_in.col  = beat_c;
    assign wb_in.data = pin_s2.dq;

    // The pins cannot be stalled, so a full buffer drops beats;
    // wbuf_ready tells the controller to hold off new writes.
    sdc_fifo #(
        .WIDTH ($bits(sdc_pkg::sdc_wbeat_t)),
        .DEPTH (WBUF_DEPTH)
    ) u_wbuf (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .clk_en    (clk_en),
        .in_valid  (beat_v & beat_wr),
        .in_ready  (wb_in_ready),
        .in_data   (wb_in),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_beat)
    );

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wbuf_ready <= 1'b1;
        end else if (clk_en) begin
            wbuf_ready <= wb_in_ready;
        end
    end

endmodule

`default_nettype wire

// file: logic/sdc_pkg.sv
// Shared constants, encodings and carriers of the two-bank DRAM core.
// Assumes a single 100 MHz clock domain for all users of this package.
`default_nettype none

package sdc_pkg;

    localparam int ADDR_W = 12;
    localparam int ROW_W  = 11;
    localparam int COL_W  = 8;
    localparam int DQ_W   = 16;
    localparam int CNT_W  = 9;
    localparam int BANKS  = 2;
    localparam int WBUF_DEPTH = 16;

    // Address line roles
    localparam int BANK_LINE = 11;
    localparam int PRE_LINE  = 10;

    // Operating mode word layout
    localparam int WM_HI = 11;
    localparam int WM_LO = 9;
    localparam int LAT_HI = 6;
    localparam int LAT_LO = 4;
    localparam int BT_BIT = 3;
    localparam int BL_HI = 2;
    localparam int BL_LO = 0;
    localparam logic [11:0] MODE_RST = 12'h020;

    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] LAT_2   = 3'h2;
    localparam logic [2:0] LAT_3   = 3'h3;
    localparam logic [2:0] WM_SINGLE = 3'h1;
    localparam logic [CNT_W-1:0] PAGE_LEN = 9'h100;
    localparam logic [ROW_W-1:0] REF_ROW_RST = 11'h000;

    typedef enum logic [3:0] {
        deselect_cmd   = 4'h0,
        nop_cmd        = 4'h1,
        burst_stop_cmd = 4'h3,
        read_cmd       = 4'h2,
        write_cmd      = 4'h6,
        row_open_cmd   = 4'h7,
        close_cmd      = 4'h5,
        refresh_cmd    = 4'h4,
        mode_load_cmd  = 4'hc
    } sdc_cmd_t;

    typedef enum logic [2:0] {
        bank_idle           = 3'h0,
        bank_active         = 3'h1,
        bank_read           = 3'h3,
        bank_write          = 3'h5,
        read_autoclose_cmd  = 3'h2,
        write_autoclose_cmd = 3'h4
    } sdc_bank_t;

    typedef struct packed {
        logic            cs_n;
        logic            ras_n;
        logic            cas_n;
        logic            we_n;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0] dq;
    } sdc_pins_t;

    localparam sdc_pins_t PINS_RST = '{1'b1, 1'b1, 1'b1, 1'b1,
                                       12'h000, 16'h0000};

    typedef struct packed {
        logic             rd;
        logic             refresh;
        logic             bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
    } sdc_arr_t;

    typedef struct packed {
        logic             bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [DQ_W-1:0]  data;
    } sdc_wbeat_t;

endpackage

`default_nettype wire

// file: logic/sdc_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; clk_en low freezes every register.
`timescale 1ns/1ns
`default_nettype none

module sdc_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,   // System clock
    input  wire logic             arst_n,    // Async reset
    input  wire logic             clk_en,    // Freeze when low
    input  wire logic             in_valid,  // Word offered
    output logic                  in_ready,  // Room for a word
    input  wire logic [WIDTH-1:0] in_data,   // Word in
    output logic                  out_valid, // Word waiting
    input  wire logic             out_ready, // Sink takes word
    output logic [WIDTH-1:0]      out_data   // Oldest word
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_idx;
    logic [AW-1:0]    rd_idx;
    logic [AW:0]      count;

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    // Wraps correctly for depths that are not a power of two
    function automatic logic [AW-1:0] step(input logic [AW-1:0] i);
        return (i == AW'(DEPTH - 1)) ? '0 : i + 1'b1;
    endfunction

    assign in_ready  = count != FULL;
    assign out_valid = count != '0;
    assign out_data  = mem[rd_idx];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count  <= '0;
        end else if (clk_en) begin
            if (push) wr_idx <= step(wr_idx);
            if (pop)  rd_idx <= step(rd_idx);
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage needs no reset; count guards every read
    always_ff @(posedge clk_sys) begin
        if (clk_en && push) begin
            mem[wr_idx] <= in_data;
        end
    end

endmodule

`default_nettype wire

// file: verification/sdc_core_assertions.sv
// Concurrent checks on the ports of the two-bank DRAM command core.
// Assumes clk_en high and commands a few cycles apart.
`timescale 1ns/1ns
`default_nettype none

module sdc_core_assertions (
    input wire logic                     clk_sys,     // Clock
    input wire logic                     arst_n,      // Async reset
    input wire sdc_pkg::sdc_pins_t       pins,        // Command pins
    input wire logic [15:0]              dq_out,      // Read word
    input wire logic                     dq_oe,       // Read word valid
    input wire sdc_pkg::sdc_arr_t        arr_req,     // Array request
    input wire logic [15:0]              arr_rd_data, // Array answer
    input wire logic                     wr_valid,    // Beat waiting
    input wire logic                     wr_ready,    // Beat taken
    input wire sdc_pkg::sdc_wbeat_t      wr_beat,     // Head beat
    input wire sdc_pkg::sdc_bank_t [1:0] bank_state,  // Bank states
    input wire logic [11:0]              operating_mode_word // Mode
);
    wire [3:0] cmd  = pins[31:28];
    // Reserved latency codes act as three cycles
    wire       lat3 = operating_mode_word[6:4] != sdc_pkg::LAT_2;
    logic [11:0] cap;
    logic [10:0] ref_row;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cap     <= 12'h000;
            ref_row <= 11'h000;
        end else begin
            if (cmd == 4'h0 || cmd == 4'h3) cap <= pins.addr;
            if (arr_req.refresh) ref_row <= ref_row + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence load_seen; cmd == 4'h0; endsequence
    sequence open_seen; cmd == 4'h3; endsequence
    sequence beat_two; ##1 dq_oe && dq_out == $past(arr_rd_data); endsequence
    sequence beat_three;
        ##2 dq_oe && dq_out == $past(arr_rd_data, 2);
    endsequence

    chk_mode_capture: assert property (
        load_seen |-> ##[2:4] operating_mode_word == cap)
        else $error("mode word not captured");
    chk_open_active: assert property (
        open_seen |-> ##[2:4] bank_state[cap[11]] == sdc_pkg::bank_active)
        else $error("opened bank not active");
    chk_close_all: assert property (
        cmd == 4'h2 && pins.addr[10] |-> ##[2:4]
        bank_state[0] == sdc_pkg::bank_idle &&
        bank_state[1] == sdc_pkg::bank_idle)
        else $error("close all left a bank open");
    chk_lat_two: assert property (
        arr_req.rd && !lat3 |-> beat_two)
        else $error("read word late or wrong at latency two");
    chk_lat_three: assert property (
        arr_req.rd && lat3 |-> beat_three)
        else $error("read word late or wrong at latency three");
    chk_no_stray: assert property (
        dq_oe |-> (lat3 ? $past(arr_req.rd, 2) : $past(arr_req.rd)))
        else $error("read word without a beat");
    chk_refresh_row: assert property (
        arr_req.refresh |-> arr_req.row == ref_row && !arr_req.rd)
        else $error("refresh row not from internal counter");
    chk_beat_hold: assert property (
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_beat))
        else $error("write beat changed while refused");
endmodule

bind sdc_core sdc_core_assertions u_chk (.*);

`default_nettype wire

// file: verification/sdc_array_model.sv
// Behavioural memory array behind the core: reads answer at once.
// Assumes one clock; stall refuses write beats to fill the buffer.
`timescale 1ns/1ns
`default_nettype none

module sdc_array_model (
    input  wire logic                clk_sys,     // Clock
    input  wire logic                arst_n,      // Async reset
    input  wire logic                stall,       // Refuse beats
    input  wire sdc_pkg::sdc_arr_t   arr_req,     // Read request
    output logic [sdc_pkg::DQ_W-1:0] arr_rd_data, // Read answer
    input  wire logic                wr_valid,    // Beat offered
    output logic                     wr_ready,    // Beat taken
    input  wire sdc_pkg::sdc_wbeat_t wr_beat      // Write beat
);
    logic [15:0] mem [512];
    logic [15:0] last;

    assign wr_ready = !stall;
    // Idle answer is the inverse of the last one, so stale data never matches
    assign arr_rd_data = arr_req.rd ? mem[{arr_req.bank, arr_req.col}] : ~last;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            last <= 16'h0000;
            for (int i = 0; i < 512; i++) mem[i] <= {i[8], 7'h2a, i[7:0]};
        end else begin
            if (arr_req.rd) last <= arr_rd_data;
            if (wr_valid && wr_ready)
                mem[{wr_beat.bank, wr_beat.col}] <= wr_beat.data;
        end
    end
endmodule

`default_nettype wire

// file: verification/sdc_core_tb.sv
// Self-checking bench for the DRAM command core and its array model.
// Assumes two-flop pin synchronisers in the core.
`timescale 1ns/1ns
`default_nettype none

module sdc_core_tb;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic stall = 1'b0;
    logic saw_full = 1'b0;
    sdc_pkg::sdc_pins_t pins = sdc_pkg::PINS_RST;
    logic [15:0] dq_out, arr_rd_data;
    logic dq_oe, wbuf_ready, wr_valid, wr_ready;
    logic [11:0] operating_mode_word;
    sdc_pkg::sdc_arr_t arr_req;
    sdc_pkg::sdc_wbeat_t wr_beat;
    sdc_pkg::sdc_bank_t [1:0] bank_state;
    logic [15:0] ref_mem [512];
    logic [15:0] got [$];
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;

    always #5 clk_sys = ~clk_sys;

    sdc_core DUT (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(1'b1),
        .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .arr_req(arr_req),
        .arr_rd_data(arr_rd_data), .wbuf_ready(wbuf_ready),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_beat(wr_beat),
        .bank_state(bank_state), .operating_mode_word(operating_mode_word));
    sdc_array_model u_arr (.*);

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("Checks %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (dq_oe === 1'b1) got.push_back(dq_out);
        if (wbuf_ready === 1'b0) saw_full = 1'b1;
        if (cyc == 30000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cmd(input logic [3:0] c, input logic [11:0] a,
                       input logic [15:0] d);
        @(negedge clk_sys);
        pins = {c, a, d};
    endtask

    task automatic idle(input int n);
        repeat (n) cmd(4'h7, 12'h000, 16'h0000);
    endtask

    task automatic st(input logic b, input sdc_pkg::sdc_bank_t s);
        chk({13'h0, bank_state[b]}, {13'h0, s});
    endtask

    // Load with both banks idle, then wait out the gap
    task automatic mode(input logic [11:0] m);
        cmd(4'h2, 12'h400, 16'h0000);
        idle(5);
        cmd(4'h0, m, 16'h0000);
        idle(5);
        chk({4'h0, operating_mode_word}, {4'h0, m});
        cmd(4'h3, 12'h005, 16'h0000);
        idle(5);
        cmd(4'h3, 12'h805, 16'h0000);
        idle(5);
        st(0, sdc_pkg::bank_active);
        st(1, sdc_pkg::bank_active);
    endtask

    // Lines 9:8 set on purpose: the column must ignore them
    task automatic rd(input logic b, input logic [7:0] c, input int n,
                      input logic ilv);
        logic [7:0] col;
        got.delete();
        cmd(4'h5, {b, 3'b011, c}, 16'h0000);
        idle(20);
        chk(16'(got.size()), 16'(n));
        for (int k = 0; k < n && k < got.size(); k++) begin
            col = ilv ? c ^ 8'(k)
                      : (c & ~8'(n - 1)) | ((c + 8'(k)) & 8'(n - 1));
            chk(got[k], ref_mem[{b, col}]);
        end
    endtask

    task automatic wr(input logic b, input logic [7:0] c, input int n,
                      input logic [15:0] d);
        cmd(4'h4, {b, 3'b000, c}, d);
        for (int k = 1; k < n; k++) cmd(4'h7, 12'h000, d + 16'(k));
        idle(10);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 512; i++) ref_mem[i] = {i[8], 7'h2a, i[7:0]};
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        chk({4'h0, operating_mode_word}, {4'h0, sdc_pkg::MODE_RST});
        idle(20000);
        cmd(4'h2, 12'h400, 16'h0000);
        idle(3);
        repeat (8) begin
            cmd(4'h1, 12'hfff, 16'hffff);
            idle(3);
        end
        mode(12'h022);
        rd(1'b0, 8'h05, 4, 1'b0);
        st(0, sdc_pkg::bank_active);
        wr(1'b1, 8'h11, 4, 16'h1000);
        for (int k = 0; k < 4; k++)
            ref_mem[{1'b1, 6'h04, 2'(k + 1)}] = 16'h1000 + 16'(k);
        rd(1'b1, 8'h11, 4, 1'b0);
        mode(12'h03b);
        rd(1'b0, 8'h0d, 8, 1'b1);
        cmd(4'h5, 12'hc20, 16'h0000);
        idle(5);
        st(1, sdc_pkg::read_autoclose_cmd);
        idle(15);
        st(1, sdc_pkg::bank_idle);
        cmd(4'h3, 12'h805, 16'h0000);
        idle(5);
        cmd(4'h5, 12'h000, 16'h0000);
        idle(1);
        cmd(4'h5, 12'h800, 16'h0000);
        idle(20);
        st(0, sdc_pkg::bank_active);
        got.delete();
        cmd(4'h5, 12'h000, 16'h0000);
        idle(2);
        cmd(4'h6, 12'h000, 16'h0000);
        idle(12);
        st(0, sdc_pkg::bank_active);
        chk(16'(got.size() < 8), 16'h0001);
        cmd(4'h2, 12'h000, 16'h0000);
        idle(5);
        st(0, sdc_pkg::bank_idle);
        st(1, sdc_pkg::bank_active);
        mode(12'h222);
        wr(1'b0, 8'h31, 4, 16'h5500);
        ref_mem[{1'b0, 8'h31}] = 16'h5500;
        rd(1'b0, 8'h31, 4, 1'b0);
        mode(12'h027);
        stall = 1'b1;
        wr(1'b1, 8'h40, 24, 16'h7000);
        cmd(4'h6, 12'h000, 16'h0000);
        chk({15'h0, saw_full}, 16'h0001);
        stall = 1'b0;
        idle(40);
        chk({15'h0, wr_valid}, 16'h0000);
        end_sim();
    end
endmodule

`default_nettype wire
